// file: verilog/pmic_sv_pkg.sv
package pmic_sv_pkg;
// ----------------------------------------------------------------
// Notes on behaviour
// - reset low while any controlling rail not okay
// - per-rail bit selects reset gating
// - disabled rail reads okay
// - enabled rail okay only once output regulates
// - hard reset holds registers at default
// - hard reset polarity is factory set
// - factory option forces supplement mode
// - 8 s watchdog runs only when enabled
// - pmic address traffic restarts watchdog
// - expiry gives soft reset or power cycle
// - cycle command drops bucks for 8 ms
// - power off bit stops all regulators
// - writes need key 0xAA at 0x0A
// - each address keeps its own key
// - over 120 C sets warning and interrupt
// - over 145 C stops bucks and boost
// - over 155 C stops everything
// - recover after 15 C fall
// - reset release delay 20/40/60/100 ms
// - watchdog expiry raises interrupt, clearing all masks
// - interrupt held until status read
// ----------------------------------------------------------------

localparam int CLK_MHZ     = 100;               // system clock rate
localparam int NUM_RAILS   = 6;                 // bucks 0..3, ldo, boost
localparam int RAIL_LDO    = 4;
localparam int RAIL_BOOST  = 5;
localparam int WD_TIME_S   = 8;                 // watchdog period
localparam int WD_CYCLES   = WD_TIME_S * CLK_MHZ * 1000000;
localparam int PC_TIME_MS  = 8;                 // buck off time
localparam int PC_CYCLES   = PC_TIME_MS * CLK_MHZ * 1000;
localparam int DLY0_MS     = 20;                // reset release delays
localparam int DLY1_MS     = 40;
localparam int DLY2_MS     = 60;
localparam int DLY3_MS     = 100;
localparam int DLY0_CYCLES = DLY0_MS * CLK_MHZ * 1000;
localparam int DLY1_CYCLES = DLY1_MS * CLK_MHZ * 1000;
localparam int DLY2_CYCLES = DLY2_MS * CLK_MHZ * 1000;
localparam int DLY3_CYCLES = DLY3_MS * CLK_MHZ * 1000;

// register offsets
localparam logic [7:0] REG_PWR_CMD = 8'h04;
localparam logic [7:0] REG_WD_CFG  = 8'h05;
localparam logic [7:0] REG_RST_SEL = 8'h06;
localparam logic [7:0] REG_STATUS  = 8'h07;
localparam logic [7:0] REG_MASK    = 8'h08;
localparam logic [7:0] REG_UNLOCK  = 8'h0A;
localparam logic [7:0] UNLOCK_KEY  = 8'hAA;

// field positions
localparam int CMD_CYCLE_BIT = 0;
localparam int CMD_OFF_BIT   = 1;
localparam int WD_SRE_BIT    = 0;
localparam int WD_PCE_BIT    = 1;
localparam int DLY_LSB       = 2;
localparam int ST_WD_BIT     = 3;

// values after reset
localparam logic [7:0] PWR_CMD_RST = 8'h00;
localparam logic [7:0] WD_CFG_RST  = 8'h00;
localparam logic [7:0] RST_SEL_RST = 8'h3F;
localparam logic [7:0] MASK_RST    = 8'h00;
localparam logic [7:0] KEY_RST     = 8'h00;

// factory modes of multi_pin_five
localparam logic [1:0] PIN5_NONE  = 2'h0;
localparam logic [1:0] PIN5_HARD  = 2'h1;
localparam logic [1:0] PIN5_SUPPL = 2'h2;

// asynchronous inputs, synchronised as one group
typedef struct packed {
  logic       scl;
  logic       sda;
  logic       pin5;
  logic [5:0] ok;     // rail comparators
  logic [2:0] hot;    // over 120/145/155 C
  logic [2:0] cool;   // below 105/130/140 C
} pins_t;

typedef enum logic [6:0] {
  ST_IDLE = 7'h01,
  ST_ADDR = 7'h02,
  ST_AACK = 7'h04,
  ST_RXB  = 7'h08,
  ST_WACK = 7'h10,
  ST_TXB  = 7'h20,
  ST_RACK = 7'h40
} i2c_st_t;

endpackage

// file: verilog/pmic_supervisor_control.sv
`timescale 1ns/10ps
module pmic_supervisor_control
  import pmic_sv_pkg::*;
#(
  parameter int         WD_CYC    = WD_CYCLES,
  parameter int         PC_CYC    = PC_CYCLES,
  parameter int         DLY0_CYC  = DLY0_CYCLES,
  parameter int         DLY1_CYC  = DLY1_CYCLES,
  parameter int         DLY2_CYC  = DLY2_CYCLES,
  parameter int         DLY3_CYC  = DLY3_CYCLES,
  parameter logic [6:0] PMIC_ADDR = 7'h25,
  parameter logic [6:0] PLP_ADDR  = 7'h26,
  parameter logic [1:0] PIN5_MODE = PIN5_HARD,
  parameter logic       HRST_HIGH = 1'b1
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire logic             multi_pin_five,
  input  wire logic [5:0]       rail_ok,
  input  wire logic [2:0]       temp_hot,
  input  wire logic [2:0]       temp_cool,
  output logic [NUM_RAILS-1:0]  rail_enable,
  output logic                  all_circuits_off,
  output logic                  supplement_force,
  output logic                  system_reset_out_n,
  output logic                  fault_interrupt_n
);
// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
pins_t   raw;                 // gathered pins
pins_t   sm_q;                // first stage, read by sy_q only
pins_t   sy_q;                // second stage, safe to use
pins_t   pv_q;                // previous value, for edges

assign raw = '{scl: scl_in, sda: sda_in, pin5: multi_pin_five,
               ok: rail_ok, hot: temp_hot, cool: temp_cool};
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
  begin
    sm_q <= '{scl: 1'b1, sda: 1'b1, default: '0};
    sy_q <= '{scl: 1'b1, sda: 1'b1, default: '0};
    pv_q <= '{scl: 1'b1, sda: 1'b1, default: '0};
  end
  else
  begin
    sm_q <= raw;
    sy_q <= sm_q;
    pv_q <= sy_q;
  end
// ----------------------------------------------------------------
// factory pin five options
// ----------------------------------------------------------------
// polarity fixed, hard reset level
wire hrst = (PIN5_MODE == PIN5_HARD) && (sy_q.pin5 == HRST_HIGH);
assign supplement_force = (PIN5_MODE == PIN5_SUPPL) && sy_q.pin5;
// ----------------------------------------------------------------
// i2c slave, scl sampled by clk
// ----------------------------------------------------------------
i2c_st_t    st_q;             // bus state
logic [3:0] cnt_q;            // bits in the current byte
logic [7:0] sh_q;             // receive shift
logic [7:0] tx_q;             // transmit shift
logic [7:0] ptr_q;            // register pointer
logic       rw_q;             // read transfer
logic       plp_q;            // second address selected
logic       first_q;          // next byte is the pointer
logic       nack_q;           // master refused more data
logic       oe_q;             // drive sda low
logic [7:0] rd_data;          // selected read value
wire scl_rise  = sy_q.scl & ~pv_q.scl;
wire scl_fall  = ~sy_q.scl & pv_q.scl;
wire i2c_start = sy_q.scl & pv_q.scl & pv_q.sda & ~sy_q.sda;
wire i2c_stop  = sy_q.scl & pv_q.scl & ~pv_q.sda & sy_q.sda;
wire full      = (cnt_q == 4'h8);
wire hit_pm    = (sh_q[7:1] == PMIC_ADDR);
wire hit_plp   = (sh_q[7:1] == PLP_ADDR);
wire addr_done = scl_fall & (st_q == ST_ADDR) & full;
wire byte_rx   = scl_fall & (st_q == ST_RXB) & full;
wire wr_en     = byte_rx & ~first_q;
wire tx_load   = scl_fall & (((st_q == ST_AACK) & rw_q) |
                             ((st_q == ST_RACK) & ~nack_q));
wire wd_kick   = addr_done & hit_pm;
// bus sequencing; stop and start win over bit edges
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
  begin
    st_q    <= ST_IDLE;
    cnt_q   <= 4'h0;
    sh_q    <= 8'h00;
    tx_q    <= 8'h00;
    ptr_q   <= 8'h00;
    rw_q    <= 1'b0;
    plp_q   <= 1'b0;
    first_q <= 1'b0;
    nack_q  <= 1'b0;
  end
  else if (i2c_stop)
    st_q <= ST_IDLE;
  else if (i2c_start)
  begin
    st_q  <= ST_ADDR;
    cnt_q <= 4'h0;
  end
  else if (scl_rise) // data is valid while scl is high
  begin
    if (st_q == ST_RACK)
      nack_q <= sy_q.sda;
    if (st_q == ST_ADDR || st_q == ST_RXB)
      sh_q <= {sh_q[6:0], sy_q.sda};
    if (st_q == ST_ADDR || st_q == ST_RXB || st_q == ST_TXB)
      cnt_q <= cnt_q + 4'h1;
  end
  else if (scl_fall)
  begin
    case (st_q)
      ST_ADDR:
        if (full) // unknown address: stay silent till next start
        begin
          st_q  <= (hit_pm | hit_plp) ? ST_AACK : ST_IDLE;
          rw_q  <= sh_q[0];
          plp_q <= hit_plp;
          cnt_q <= 4'h0;
        end
      ST_AACK:
      begin
        st_q    <= rw_q ? ST_TXB : ST_RXB;
        tx_q    <= rd_data;
        first_q <= 1'b1;
      end
      ST_RXB:
        if (full)
        begin
          st_q  <= ST_WACK;
          cnt_q <= 4'h0;
          ptr_q <= first_q ? sh_q : ptr_q + 8'h01;
        end
      ST_WACK:
      begin
        st_q    <= ST_RXB;
        first_q <= 1'b0;
      end
      ST_TXB:
        if (full)
        begin
          st_q  <= ST_RACK;
          ptr_q <= ptr_q + 8'h01;
        end
        else
          tx_q <= {tx_q[6:0], 1'b0};
      ST_RACK:
        if (nack_q)
          st_q <= ST_IDLE;
        else
        begin
          st_q  <= ST_TXB;
          tx_q  <= rd_data;
          cnt_q <= 4'h0;
        end
      default:
        st_q <= st_q;
    endcase
  end
// open-drain data line: only ever pulled low
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    oe_q <= 1'b0;
  else
    oe_q <= (st_q == ST_AACK) | (st_q == ST_WACK) |
            ((st_q == ST_TXB) & ~tx_q[7]);
assign sda_oe  = oe_q;
assign sda_out = 1'b0;
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
logic [7:0] pwr_cmd_q;        // power command control
logic [7:0] wd_cfg_q;         // watchdog enables and delay
logic [7:0] rsel_q;           // reset gating per rail
logic [7:0] mask_q;           // interrupt masks
logic [7:0] key_pm_q;         // key, pmic address
logic [7:0] key_plp_q;        // key, second address
logic [3:0] stat_q;           // sticky status
logic [2:0] trip_q;           // thermal trips
logic       wd_expire;        // watchdog end pulse
// each address has its own key
wire unlocked = plp_q ? (key_plp_q == UNLOCK_KEY)
                      : (key_pm_q == UNLOCK_KEY);
wire wr_ok    = wr_en & (unlocked | (ptr_q == REG_UNLOCK));
wire pm_wr    = wr_ok & ~plp_q;
wire mr_wr    = pm_wr & (ptr_q == REG_PWR_CMD) & sh_q[CMD_CYCLE_BIT];
wire stat_rd  = tx_load & ~plp_q & (ptr_q == REG_STATUS);
wire sre      = wd_cfg_q[WD_SRE_BIT];
wire pce      = wd_cfg_q[WD_PCE_BIT];
wire soft_rst = wd_expire & sre & ~pce;
wire pc_start = mr_wr | (wd_expire & pce);
wire power_off = pwr_cmd_q[CMD_OFF_BIT];
// hard reset, cycle command and watchdog expiry load the reset values
wire reg_clr   = hrst | mr_wr | wd_expire;
// read data; the second address only shows its key
assign rd_data = plp_q ? ((ptr_q == REG_UNLOCK) ? key_plp_q : 8'h00) :
                 (ptr_q == REG_PWR_CMD) ? pwr_cmd_q :
                 (ptr_q == REG_WD_CFG)  ? wd_cfg_q :
                 (ptr_q == REG_RST_SEL) ? rsel_q :
                 (ptr_q == REG_STATUS)  ? {4'h0, stat_q} :
                 (ptr_q == REG_MASK)    ? mask_q :
                 (ptr_q == REG_UNLOCK)  ? key_pm_q : 8'h00;
// writable registers; the clear is synchronous, not a reset
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
  begin
    pwr_cmd_q <= PWR_CMD_RST;
    wd_cfg_q  <= WD_CFG_RST;
    rsel_q    <= RST_SEL_RST;
    mask_q    <= MASK_RST;
    key_pm_q  <= KEY_RST;
    key_plp_q <= KEY_RST;
  end
  else if (reg_clr)
  begin
    pwr_cmd_q <= PWR_CMD_RST;
    wd_cfg_q  <= WD_CFG_RST;
    rsel_q    <= RST_SEL_RST;
    mask_q    <= MASK_RST;
    key_pm_q  <= KEY_RST;
    key_plp_q <= KEY_RST;
  end
  else
  begin
    if (pm_wr && ptr_q == REG_PWR_CMD) // cycle bit self clears, never stored
      pwr_cmd_q <= {sh_q[7:1], 1'b0};
    if (pm_wr && ptr_q == REG_WD_CFG)
      wd_cfg_q <= sh_q;
    if (pm_wr && ptr_q == REG_RST_SEL)
      rsel_q <= sh_q;
    if (pm_wr && ptr_q == REG_MASK)
      mask_q <= sh_q;
    if (wr_ok && ptr_q == REG_UNLOCK && !plp_q)
      key_pm_q <= sh_q;
    if (wr_ok && ptr_q == REG_UNLOCK && plp_q)
      key_plp_q <= sh_q;
  end
// trip holds until the cool comparator clears it
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    trip_q <= 3'h0;
  else
    trip_q <= sy_q.hot | (trip_q & ~sy_q.cool);
wire [3:0] stat_set = {wd_expire, trip_q};
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    stat_q <= 4'h0;
  else
    stat_q <= stat_set | (stat_q & {4{~(stat_rd | reg_clr)}});
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    fault_interrupt_n <= 1'b1;
  else
    fault_interrupt_n <= ~|(stat_q & ~mask_q[3:0]);
// ----------------------------------------------------------------
// watchdog and power cycle
// ----------------------------------------------------------------
logic [31:0] wd_cnt_q;        // time since the last pmic address
logic [31:0] pc_cnt_q;        // remaining buck off time
wire         wd_en = sre | pce;
wire         pc_busy = |pc_cnt_q;
// counts only when enabled, kicked by traffic
assign wd_expire = wd_en & (wd_cnt_q == 32'(WD_CYC - 1));
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    wd_cnt_q <= 32'h0;
  else if (!wd_en || wd_kick || wd_expire)
    wd_cnt_q <= 32'h0;
  else
    wd_cnt_q <= wd_cnt_q + 32'h1;
// bucks off for a fixed time
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    pc_cnt_q <= 32'h0;
  else if (pc_start)
    pc_cnt_q <= 32'(PC_CYC);
  else if (pc_busy)
    pc_cnt_q <= pc_cnt_q - 32'h1;
// ----------------------------------------------------------------
// rail enables
// ----------------------------------------------------------------
// ldo and boost survive a cycle
wire base_on  = ~hrst & ~power_off & ~trip_q[2];
wire buck_on  = base_on & ~pc_busy & ~trip_q[1];
wire boost_on = base_on & ~trip_q[1];
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
    rail_enable <= '0;
  else
    rail_enable <= {boost_on, base_on, {4{buck_on}}};
assign all_circuits_off = trip_q[2];
// ----------------------------------------------------------------
// system reset output
// ----------------------------------------------------------------
logic [31:0] rst_cnt_q;       // time since rails good
wire  [1:0]  dsel = wd_cfg_q[DLY_LSB +: 2];
wire [5:0] ok_eff  = ~rail_enable | sy_q.ok;
wire       ctrl_ok = &(~rsel_q[5:0] | ok_eff);
wire       hold    = ~ctrl_ok | soft_rst | hrst | power_off |
                     pc_busy | trip_q[2];
wire [31:0] dly = (dsel == 2'h0) ? 32'(DLY0_CYC) :
                  (dsel == 2'h1) ? 32'(DLY1_CYC) :
                  (dsel == 2'h2) ? 32'(DLY2_CYC) : 32'(DLY3_CYC);
wire rst_done = (rst_cnt_q >= dly);
always_ff @(posedge clk or negedge rst_b)
  if (!rst_b)
  begin
    rst_cnt_q          <= 32'h0;
    system_reset_out_n <= 1'b0;
  end
  else
  begin
    rst_cnt_q          <= hold ? 32'h0 : rst_cnt_q + {31'h0, ~rst_done};
    system_reset_out_n <= ~hold & rst_done;
  end
// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
sequence bucks_off_s;
  (rail_enable[3:0] == 4'h0) [*2];
endsequence
rst_hold_a: assert property (!ctrl_ok |=> !system_reset_out_n)
  else $error("reset released with a rail not okay");
rst_delay_a: assert property ($rose(system_reset_out_n) |->
  $past(rst_cnt_q) >= dly)
  else $error("reset released before delay");
off_rail_a: assert property ((rail_enable == '0) |-> ctrl_ok)
  else $error("disabled rail held reset");
hard_rst_a: assert property (hrst |=> rail_enable == '0 &&
  key_pm_q == KEY_RST)
  else $error("hard reset left state active");
wd_idle_a: assert property (!wd_en |=> wd_cnt_q == 32'h0)
  else $error("watchdog counted while disabled");
wd_action_a: assert property (wd_expire && pce |=> pc_busy)
  else $error("expiry did not power cycle");
cycle_bucks_a: assert property (pc_start |=> ##1 bucks_off_s)
  else $error("bucks stayed on in power cycle");
pwr_off_a: assert property (power_off |=> rail_enable == '0)
  else $error("rails on during power off");
locked_wr_a: assert property (wr_en && !unlocked &&
  ptr_q != REG_UNLOCK |=> $stable(rsel_q) && $stable(mask_q))
  else $error("write accepted while locked");
hot_off_a: assert property (trip_q[1] |=>
  !rail_enable[RAIL_BOOST] && rail_enable[3:0] == 4'h0)
  else $error("converters on above power-down point");
irq_hold_a: assert property ((stat_q & ~mask_q[3:0]) != 4'h0
  |=> !fault_interrupt_n)
  else $error("pending status without interrupt");
endmodule // pmic_supervisor_control

// file: tb/i2c_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host processor on the two-wire bus, 125 ns link period
// ----------------------------------------------------------------
module i2c_host_model (
  output logic scl,
  output wire  sda,
  input  wire  logic sda_oe
);
  localparam realtime QTR = 31.25;  // quarter of the link period
  logic               pull_q;       // host pulls sda low

  // open drain wire with pull-up: low while any party pulls it
  assign sda = !(pull_q || sda_oe);

  // scl stands high between frames, the wire is released
  initial
  begin
    scl    = 1'b1;
    pull_q = 1'b0;
  end

  // data moves only while scl is low, sampled on the scl rise
  task automatic clk_bit(input logic b, output logic s);
    #QTR pull_q = !b;
    #QTR scl = 1'b1;
    s = sda;
    #(2*QTR) scl = 1'b0;
  endtask

  // also serves as repeated start after an acknowledge
  task automatic start_c;
    #QTR pull_q = 1'b0;
    #QTR scl = 1'b1;
    #QTR pull_q = 1'b1;
    #QTR scl = 1'b0;
  endtask

  task automatic stop_c;
    #QTR pull_q = 1'b1;
    #QTR scl = 1'b1;
    #QTR pull_q = 1'b0;
    #QTR;
  endtask

  // byte out msb first, ok set when the device pulled the ninth bit
  task automatic put_byte(input logic [7:0] d, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ok = !s;
  endtask

  // single byte read, host answers with no acknowledge to end it
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(1'b1, s);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] idx,
                           input logic [7:0] val, output logic ok);
    logic a0, a1, a2;
    start_c();
    put_byte({dev, 1'b0}, a0);
    put_byte(idx, a1);
    put_byte(val, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] idx,
                          output logic [7:0] val, output logic ok);
    logic a0, a1, a2;
    start_c();
    put_byte({dev, 1'b0}, a0);
    put_byte(idx, a1);
    start_c();
    put_byte({dev, 1'b1}, a2);
    get_byte(val);
    stop_c();
    ok = a0 & a1 & a2;
  endtask
endmodule // i2c_host_model

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import pmic_sv_pkg::*;
  localparam logic [6:0] PM = 7'h25;     // power management address
  localparam logic [6:0] PL = 7'h26;     // protection address
  localparam int         DLY0 = 50;      // shortened release delay
  localparam int         PCC  = 200;     // shortened buck off time
  logic       clk, rst_b, pin5, scl, sda_oe, sda_out;
  logic       circ_off, suppl, rst_out_n, irq_n;
  logic [5:0] rail_ok, rail_bad, rail_en;
  logic [2:0] hot, cool;
  wire        sda;
  int         errors, compares;

  pmic_supervisor_control #(.WD_CYC(2000), .PC_CYC(PCC), .DLY0_CYC(DLY0),
    .DLY1_CYC(100), .DLY2_CYC(150), .DLY3_CYC(250)) u_pmic_supervisor_control (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .multi_pin_five(pin5), .rail_ok(rail_ok),
    .temp_hot(hot), .temp_cool(cool), .rail_enable(rail_en),
    .all_circuits_off(circ_off), .supplement_force(suppl),
    .system_reset_out_n(rst_out_n), .fault_interrupt_n(irq_n));

  i2c_host_model u_i2c_host_model (.scl(scl), .sda(sda), .sda_oe(sda_oe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // rail comparators: good unless a scenario marks a rail bad
  always @(posedge clk)
    rail_ok <= ~rail_bad;

  // hang guard, well above the expected run length
  initial
  begin
    #900000;
    errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] idx, input logic [7:0] val);
    logic ok;
    u_i2c_host_model.write_reg(dev, idx, val, ok);
    chk("write ack", 8'h01, {7'h0, ok});
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] idx, input logic [7:0] exp);
    logic       ok;
    logic [7:0] v;
    u_i2c_host_model.read_reg(dev, idx, v, ok);
    chk("read data", exp, v);
  endtask

  task automatic end_sim;
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_startup;
    cyc(45);
    chk("reset out early", 8'h00, {7'h0, rst_out_n});
    cyc(25);
    chk("reset out", 8'h01, {7'h0, rst_out_n});
    chk("rails", 8'h3F, {2'h0, rail_en});
    rd(PM, REG_PWR_CMD, PWR_CMD_RST);
    rd(PM, REG_UNLOCK, KEY_RST);
    cyc(2100);
    chk("idle irq", 8'h01, {7'h0, irq_n});
  endtask

  task automatic t_lock;
    logic ok;
    wr(PM, REG_RST_SEL, 8'h3E);
    rd(PM, REG_RST_SEL, RST_SEL_RST);
    wr(PL, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_RST_SEL, 8'h3E);
    rd(PM, REG_RST_SEL, RST_SEL_RST);
    rd(PL, REG_RST_SEL, 8'h00);
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_RST_SEL, 8'h3E);
    rd(PM, REG_RST_SEL, 8'h3E);
    cyc(1);
    rail_bad <= 6'h01;
    cyc(10);
    chk("unselected rail", 8'h01, {7'h0, rst_out_n});
    rail_bad <= 6'h02;
    cyc(10);
    chk("selected rail", 8'h00, {7'h0, rst_out_n});
    rail_bad <= 6'h00;
    cyc(DLY0 + 20);
    chk("rail back", 8'h01, {7'h0, rst_out_n});
    wr(PM, REG_UNLOCK, 8'h55);
    wr(PM, REG_RST_SEL, 8'h3F);
    rd(PM, REG_RST_SEL, 8'h3E);
    u_i2c_host_model.write_reg(7'h27, 8'h00, 8'h00, ok);
    chk("foreign address ack", 8'h00, {7'h0, ok});
  endtask

  task automatic t_cycle;
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_PWR_CMD, 8'h01);
    chk("bucks off", 8'h30, {2'h0, rail_en});
    cyc(PCC + 20);
    chk("bucks back", 8'h3F, {2'h0, rail_en});
    rd(PM, REG_RST_SEL, RST_SEL_RST);
    rd(PM, REG_PWR_CMD, 8'h00);
  endtask

  task automatic t_off;
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_PWR_CMD, 8'h02);
    cyc(60);
    chk("all off", 8'h00, {2'h0, rail_en});
    chk("off reset", 8'h00, {7'h0, rst_out_n});
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_PWR_CMD, 8'h00);
    cyc(10);
    chk("restart", 8'h3F, {2'h0, rail_en});
  endtask

  task automatic t_hard;
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_RST_SEL, 8'h3E);
    cyc(1);
    pin5 <= 1'b1;
    cyc(10);
    chk("hard rails", 8'h00, {2'h0, rail_en});
    chk("hard reset out", 8'h00, {7'h0, rst_out_n});
    chk("no supplement", 8'h00, {7'h0, suppl});
    pin5 <= 1'b0;
    cyc(10);
    rd(PM, REG_RST_SEL, RST_SEL_RST);
    chk("soft start", 8'h3F, {2'h0, rail_en});
  endtask

  task automatic t_thermal;
    cyc(1);
    hot <= 3'b001;
    cool <= 3'b110;
    cyc(10);
    chk("warn irq", 8'h00, {7'h0, irq_n});
    rd(PM, REG_STATUS, 8'h01);
    cyc(1);
    hot <= 3'b011;
    cool <= 3'b100;
    cyc(10);
    chk("converters off", 8'h10, {2'h0, rail_en});
    hot <= 3'b111;
    cool <= 3'b000;
    cyc(10);
    chk("full off", 8'h01, {7'h0, circ_off});
    hot <= 3'b011;
    cyc(10);
    chk("hysteresis", 8'h01, {7'h0, circ_off});
    hot <= 3'b000;
    cool <= 3'b111;
    cyc(10);
    chk("recovered", 8'h00, {7'h0, circ_off});
    chk("rails recovered", 8'h3F, {2'h0, rail_en});
    chk("irq held", 8'h00, {7'h0, irq_n});
    rd(PM, REG_STATUS, 8'h07);
    cyc(10);
    chk("irq cleared", 8'h01, {7'h0, irq_n});
  endtask

  // expiry lands WD_CYC cycles after the status read kick or the enabling write, bucks stay off PCC
  task automatic t_watch;
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_WD_CFG, 8'h01);
    cyc(1200);
    rd(PM, REG_STATUS, 8'h00);
    cyc(1200);
    chk("kicked irq", 8'h01, {7'h0, irq_n});
    cyc(1000);
    chk("expiry irq", 8'h00, {7'h0, irq_n});
    chk("soft reset rails", 8'h3F, {2'h0, rail_en});
    rd(PM, REG_STATUS, 8'h08);
    wr(PM, REG_UNLOCK, UNLOCK_KEY);
    wr(PM, REG_WD_CFG, 8'h02);
    cyc(2040);
    chk("wd bucks off", 8'h30, {2'h0, rail_en});
    cyc(250);
    chk("wd bucks back", 8'h3F, {2'h0, rail_en});
  endtask

  initial
  begin
    rst_b    = 1'b0;
    pin5     = 1'b0;
    rail_bad = 6'h00;
    hot      = 3'b000;
    cool     = 3'b111;
    errors   = 0;
    compares = 0;
    cyc(5);
    rst_b <= 1'b1;
    t_startup();
    t_lock();
    t_cycle();
    t_off();
    t_hard();
    t_thermal();
    t_watch();
    end_sim();
  end
endmodule // testbench
